// file: core/mpcg_pkg.sv
// Constants and state layout shared by the phase-selectable clock generator.
package mpcg_pkg;

    // Timing figures in their own units and the cycle counts derived from them.
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned PHASE_STEP_PS  = 2500;
    localparam int unsigned STEP_CYC_RAW   = (PHASE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STEP_CYC       = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
    localparam int unsigned LOCK_TIME_US   = 500;
    localparam int unsigned LOCK_TIME_CYC  = (LOCK_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;

    // Widths and limits.
    localparam int unsigned NUM_OUT        = 6;
    localparam int unsigned PH_W           = 12;
    localparam logic [11:0] PH_MAX         = 12'hfff;
    localparam logic [3:0]  LOCK_PERIODS   = 4'h8;
    localparam int unsigned WD_W           = 17;

    // Base offsets per select code, four signed bits per output, output 0 lowest.
    localparam logic [23:0] OFF_SEL0       = 24'h000000;
    localparam logic [23:0] OFF_SEL1       = 24'h00f100;
    localparam logic [23:0] OFF_SEL2       = 24'hef0010;
    localparam logic [23:0] OFF_SEL3       = 24'heff110;
    localparam logic [5:0]  INV_SEL0       = 6'h20;
    localparam logic [5:0]  INV_SEL1       = 6'h20;
    localparam logic [5:0]  INV_SEL2       = 6'h00;
    localparam logic [5:0]  INV_SEL3       = 6'h00;

    typedef struct packed {
        logic        ref_q;
        logic        fb_q;
        logic        seen;
        logic [11:0] ph;
        logic [11:0] per;
        logic        per_ok;
        logic [11:0] corr;
        logic [3:0]  lock_cnt;
        logic        valid;
        logic [1:0]  sel_q;
        logic [16:0] wd;
        logic [5:0]  outs;
    } mpcg_state_t;

endpackage

// file: core/mpcg_top.sv
// Phase-selectable six-output clock generator locked to a reference clock.
//
// Functional notes
// (R1) Select pins plus fed-back output choose one of fourteen phase patterns.
// (R2) Each output sits at its own offset: zero, plus/minus steps, or inverted.
// (R3) All offsets are counted in whole phase steps.
// (R4) Zero-offset output rises with the reference rising edge.
// (R5) Negative offset output rises that many steps before the reference edge.
// (R6) Positive offset output rises that many steps after the reference edge.
// (R7) Inverted output is half a period away, plus any step offset.
// (R8) Step is a fixed digital fraction of the reference period; the code keeps each step at STEP_CYC clock cycles whatever the period.
// (R9) Output edges move earlier or later in 2.5 ns steps; the code rounds each step up to one 5 ns clock cycle.
// (R10) Feedback rising edge is kept aligned with reference rising edge.
// (R11) Outputs run at half high, half low, whatever the reference duty.
// (R12) Lock is reached within 500 us; outputs are invalid before that.
// (R13) Board may tie together outputs of equal phase for more drive.
// (R14) One step equals one period of the fast internal oscillator.
// (R15) Feedback must be continuous and derived from one of the outputs.
// (R16) Select inputs are active-high static levels.
// (R17) A select change restarts the lock interval before phases are valid.
`timescale 1ns/1ps

module mpcg_top #(
    parameter int unsigned LOCK_TIME_CYCLES = mpcg_pkg::LOCK_TIME_CYC
) (
    // Clock and reset.
    input  wire logic CLK,
    input  wire logic RST,
    // Reference and feedback.
    input  wire logic REFERENCE_CLOCK_IN,
    input  wire logic FEEDBACK_CLOCK_IN,
    // Phase pattern select.
    input  wire logic PHASE_SELECT_HIGH,
    input  wire logic PHASE_SELECT_LOW,
    // Output clocks and lock status.
    output logic      OUT_CLOCK_0,
    output logic      OUT_CLOCK_1,
    output logic      OUT_CLOCK_2,
    output logic      OUT_CLOCK_3,
    output logic      OUT_CLOCK_4,
    output logic      OUT_CLOCK_5,
    output logic      OUTPUTS_LOCKED
);

    ////////////////////////////////////////////////////////////////////////////////

    // Reduces a value into one reference period; the span is at most two periods each way.
    function automatic logic [11:0] wrap(input logic signed [14:0] v, input logic [11:0] p);
        logic signed [14:0] x;
        logic signed [14:0] ps;
        x  = v;
        ps = $signed({3'b000, p});
        if (x < 0) begin
            x = x + ps;
        end
        if (x < 0) begin
            x = x + ps;
        end
        if (x >= ps) begin
            x = x - ps;
        end
        if (x >= ps) begin
            x = x - ps;
        end
        return x[11:0];
    endfunction

    function automatic logic [23:0] base_table(input logic [1:0] sel);
        case (sel)
            2'b00:   base_table = mpcg_pkg::OFF_SEL0;
            2'b01:   base_table = mpcg_pkg::OFF_SEL1;
            2'b10:   base_table = mpcg_pkg::OFF_SEL2;
            default: base_table = mpcg_pkg::OFF_SEL3;
        endcase
    endfunction

    function automatic logic [5:0] inv_table(input logic [1:0] sel);
        case (sel)
            2'b00:   inv_table = mpcg_pkg::INV_SEL0;
            2'b01:   inv_table = mpcg_pkg::INV_SEL1;
            2'b10:   inv_table = mpcg_pkg::INV_SEL2;
            default: inv_table = mpcg_pkg::INV_SEL3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    mpcg_pkg::mpcg_state_t s;
    mpcg_pkg::mpcg_state_t next_s;

    logic [1:0]  sel;
    logic        ref_rise;
    logic        fb_rise;
    logic [11:0] half;
    logic [11:0] next_ph;
    logic [11:0] fb_err;
    logic [23:0] base_vec;
    logic [5:0]  inv_vec;
    logic [11:0] eff [6];
    logic [5:0]  cand;

    assign sel      = {PHASE_SELECT_HIGH, PHASE_SELECT_LOW};
    assign ref_rise = REFERENCE_CLOCK_IN & ~s.ref_q;
    assign fb_rise  = FEEDBACK_CLOCK_IN & ~s.fb_q;
    assign half     = s.per >> 1;
    assign base_vec = base_table(sel); // (R1)
    assign inv_vec  = inv_table(sel);
    assign next_ph  = ref_rise ? 12'h000 : ((s.ph == mpcg_pkg::PH_MAX) ? s.ph : s.ph + 12'h001); // (R14)
    assign fb_err   = wrap($signed({3'b000, s.ph}) + 15'sh0001, s.per);

    // Each output's rising edge position within the reference period.
    // The whole pattern is shifted by the loop correction, which is how the fed-back
    // output's choice selects among the patterns of one select code.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_out
            logic [3:0]         b;
            logic signed [14:0] boff;
            logic signed [14:0] ioff;
            assign b    = base_vec[4*gi +: 4];
            assign boff = $signed({{11{b[3]}}, b}) * $signed(15'(mpcg_pkg::STEP_CYC)); // (R3)
            assign ioff = inv_vec[gi] ? $signed({3'b000, half}) : 15'sh0000; // (R7)
            assign eff[gi] = wrap(boff + ioff + $signed({3'b000, s.corr}), s.per); // (R2)
            assign cand[gi] = s.per_ok &&
                (wrap($signed({3'b000, next_ph}) - $signed({3'b000, eff[gi]}), s.per) < half); // (R11)
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s       = s;
        next_s.ref_q = REFERENCE_CLOCK_IN;
        next_s.fb_q  = FEEDBACK_CLOCK_IN;
        next_s.sel_q = sel;
        next_s.ph    = next_ph;
        next_s.outs  = cand;
        // Period measured digitally; the step stays at STEP_CYC clock cycles whatever the period.
        if (ref_rise) begin
            next_s.seen   = 1'b1;
            next_s.per    = s.ph + 12'h001; // (R8)
            next_s.per_ok = s.seen && (s.ph != mpcg_pkg::PH_MAX) && (s.ph != 12'h000);
            if (next_s.per != s.per) begin
                next_s.lock_cnt = 4'h0;
                next_s.valid    = 1'b0;
            end else if (fb_rise && s.per_ok) begin
                if (s.lock_cnt != mpcg_pkg::LOCK_PERIODS) begin
                    next_s.lock_cnt = s.lock_cnt + 4'h1;
                end
                next_s.valid = (next_s.lock_cnt == mpcg_pkg::LOCK_PERIODS); // (R12)
            end else begin
                // A reference edge without its feedback edge means the loop is open.
                next_s.lock_cnt = 4'h0;
                next_s.valid    = 1'b0; // (R10)
            end
        end else if (s.ph == mpcg_pkg::PH_MAX) begin
            // A stopped reference drops lock rather than freezing stale phases.
            next_s.per_ok   = 1'b0;
            next_s.lock_cnt = 4'h0;
            next_s.valid    = 1'b0;
        end
        // A feedback edge away from the reference edge pulls the pattern by its error.
        if (fb_rise && !ref_rise && s.per_ok && fb_err != 12'h000) begin
            next_s.corr     = wrap($signed({3'b000, s.corr}) - $signed({3'b000, fb_err}),
                                   s.per); // (R10)
            next_s.lock_cnt = 4'h0;
            next_s.valid    = 1'b0;
        end
        // Watchdog restarts acquisition when lock is not reached in time.
        if (s.valid) begin
            next_s.wd = '0;
        end else if (s.wd == 17'(LOCK_TIME_CYCLES)) begin
            next_s.wd       = '0;
            next_s.corr     = 12'h000;
            next_s.lock_cnt = 4'h0; // (R12)
        end else begin
            next_s.wd = s.wd + 17'h00001;
        end
        if (sel != s.sel_q) begin
            next_s.lock_cnt = 4'h0;
            next_s.valid    = 1'b0;
            next_s.wd       = '0; // (R17)
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign OUT_CLOCK_0    = s.outs[0];
    assign OUT_CLOCK_1    = s.outs[1];
    assign OUT_CLOCK_2    = s.outs[2];
    assign OUT_CLOCK_3    = s.outs[3];
    assign OUT_CLOCK_4    = s.outs[4];
    assign OUT_CLOCK_5    = s.outs[5];
    assign OUTPUTS_LOCKED = s.valid;

    ////////////////////////////////////////////////////////////////////////////////

    // High-time counter of output 0, read only by the duty check.
    logic [11:0] hi0;
    always_ff @(posedge CLK) begin
        if (RST) begin
            hi0 <= 12'h000;
        end else begin
            hi0 <= OUT_CLOCK_0 ? hi0 + 12'h001 : 12'h000;
        end
    end

    property p_sel_relock;
        @(posedge CLK) disable iff (RST)
        (sel != s.sel_q) |=> !OUTPUTS_LOCKED [*2];
    endproperty
    a_sel_relock: assert property (p_sel_relock) else $error("lock kept across select change"); // (R17)

    property p_fb_align;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && fb_rise) |-> ref_rise;
    endproperty
    a_fb_align: assert property (p_fb_align) else $error("feedback edge off reference edge"); // (R10)

    property p_lock_time;
        @(posedge CLK) disable iff (RST)
        !OUTPUTS_LOCKED |-> (s.wd <= 17'(LOCK_TIME_CYCLES));
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("acquisition overran lock time"); // (R12)

    property p_duty;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && $past(OUTPUTS_LOCKED, 2) && $fell(OUT_CLOCK_0)) |-> (hi0 == half);
    endproperty
    a_duty: assert property (p_duty) else $error("output high time is not half period"); // (R11)

    property p_zero_align;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && ref_rise && eff[0] == 12'h000) |=> $rose(OUT_CLOCK_0);
    endproperty
    a_zero_align: assert property (p_zero_align) else $error("zero offset output not aligned"); // (R4)

    property p_rise_at_offset;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && $past(OUTPUTS_LOCKED) && sel == s.sel_q && $rose(OUT_CLOCK_3)) |->
            (s.ph == eff[3]);
    endproperty
    a_rise_at_offset: assert property (p_rise_at_offset) else $error("edge not at offset"); // (R5)

    property p_inverted;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && sel == 2'b00 && !s.per[0] && $stable(s.corr)) |->
            (OUT_CLOCK_5 != OUT_CLOCK_0);
    endproperty
    a_inverted: assert property (p_inverted) else $error("inverted output not complement"); // (R7)

    property p_step;
        @(posedge CLK) disable iff (RST)
        (s.per_ok && sel == 2'b01) |->
            (eff[2] == wrap($signed({3'b000, eff[0]}) + $signed(15'(mpcg_pkg::STEP_CYC)), s.per));
    endproperty
    a_step: assert property (p_step) else $error("late output not one step behind"); // (R9)

    // Outputs are compared against the offsets of the select code they were built from.
    property p_late_rise;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && $past(OUTPUTS_LOCKED) && sel == s.sel_q && $rose(OUT_CLOCK_1)) |->
            (s.ph == eff[1]);
    endproperty
    a_late_rise: assert property (p_late_rise) else $error("late edge not at offset"); // (R6)

    property p_drop_on_miss;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && ref_rise && !fb_rise) |=> !OUTPUTS_LOCKED;
    endproperty
    a_drop_on_miss: assert property (p_drop_on_miss) else $error("lock kept open loop"); // (R10)

    property p_lock_count;
        @(posedge CLK) disable iff (RST)
        $rose(OUTPUTS_LOCKED) |-> (s.lock_cnt == mpcg_pkg::LOCK_PERIODS);
    endproperty
    a_lock_count: assert property (p_lock_count) else $error("lock without full count"); // (R12)

    property p_per_hold;
        @(posedge CLK) disable iff (RST)
        !ref_rise |=> $stable(s.per);
    endproperty
    a_per_hold: assert property (p_per_hold) else $error("period moved between edges"); // (R8)

    property p_outs_quiet;
        @(posedge CLK) disable iff (RST)
        !s.per_ok |=> (s.outs == 6'h00);
    endproperty
    a_outs_quiet: assert property (p_outs_quiet) else $error("outputs run unmeasured"); // (R12)

    property p_equal_phase;
        @(posedge CLK) disable iff (RST)
        (s.sel_q == 2'b00) |-> (OUT_CLOCK_1 == OUT_CLOCK_0 && OUT_CLOCK_2 == OUT_CLOCK_0 &&
            OUT_CLOCK_3 == OUT_CLOCK_0 && OUT_CLOCK_4 == OUT_CLOCK_0);
    endproperty
    a_equal_phase: assert property (p_equal_phase) else $error("aligned outputs differ"); // (R2)

    property p_inverted_late;
        @(posedge CLK) disable iff (RST)
        (OUTPUTS_LOCKED && s.sel_q == 2'b01 && sel == s.sel_q && !s.per[0] &&
            $stable(s.per)) |-> (OUT_CLOCK_5 != OUT_CLOCK_0);
    endproperty
    a_inverted_late: assert property (p_inverted_late) else $error("inverted output wrong"); // (R7)

endmodule // mpcg_top

// file: verification/mpcg_ref_src.sv
// Reference clock source and delayed feedback path for the clock generator.
`timescale 1ns/1ps

module mpcg_ref_src (
    // Bench clock and settings.
    input  wire logic       clk,
    input  wire logic [3:0] period,
    input  wire logic [3:0] hi_w,
    input  wire logic [1:0] dly,
    input  wire logic [2:0] fb_sel,
    input  wire logic       gate,
    // Board side of the generator.
    input  wire logic [5:0] outs,
    output logic            ref_clk,
    output logic            fb_clk
);
    int         cnt  = 0;
    logic [3:0] line = 4'h0;

    initial ref_clk = 1'b0;

    ////////////////////////////////////////
    // The reference runs free with whatever duty the bench picks.
    always @(negedge clk) begin
        cnt = (cnt >= period - 1) ? 0 : cnt + 1;
        ref_clk <= (cnt < hi_w);
    end

    ////////////////////////////////////////
    // Feedback is one output passed through whole-cycle board delays.
    always @(posedge clk) begin
        line <= {line[2:0], outs[fb_sel]};
    end

    // Gating breaks the loop on purpose, as a careless board would.
    assign fb_clk = gate ? 1'b0 : (dly == 2'h0) ? outs[fb_sel] : line[dly - 2'h1];
endmodule // mpcg_ref_src

// file: verification/testbench.sv
// Self-checking bench for the clock generator over all fourteen phase patterns.
`timescale 1ns/1ps

module testbench;
    localparam int LK = 400;
    logic       clk    = 1'b0;
    logic       rst    = 1'b1;
    logic [1:0] sel    = 2'h0;
    logic       gate   = 1'b0;
    logic [3:0] period = 4'h8;
    logic [3:0] hi_w   = 4'h4;
    logic [1:0] dly    = 2'h0;
    logic [2:0] fb_sel = 3'h0;
    logic       ref_clk;
    logic       fb_clk;
    logic       locked;
    logic [5:0] outs;
    logic [7:0] cur    = 8'h0;
    logic [7:0] prev   = 8'h0;
    int         error_cnt   = 0;
    int         comparisons = 0;
    int         cyc         = 0;
    int         off [4][6]  = '{'{0,0,0,0,0,0}, '{0,0,1,-1,0,0}, '{0,1,0,0,-1,-2},
                                '{0,1,1,-1,-1,-2}};
    int         fbt [14]    = '{0,5,0,2,3,5,0,1,4,5,0,1,3,5};

    mpcg_top #(.LOCK_TIME_CYCLES(LK)) uut (
        .CLK(clk), .RST(rst), .REFERENCE_CLOCK_IN(ref_clk), .FEEDBACK_CLOCK_IN(fb_clk),
        .PHASE_SELECT_HIGH(sel[1]), .PHASE_SELECT_LOW(sel[0]),
        .OUT_CLOCK_0(outs[0]), .OUT_CLOCK_1(outs[1]), .OUT_CLOCK_2(outs[2]),
        .OUT_CLOCK_3(outs[3]), .OUT_CLOCK_4(outs[4]), .OUT_CLOCK_5(outs[5]),
        .OUTPUTS_LOCKED(locked));

    mpcg_ref_src src (.clk(clk), .period(period), .hi_w(hi_w), .dly(dly), .fb_sel(fb_sel),
        .gate(gate), .outs(outs), .ref_clk(ref_clk), .fb_clk(fb_clk));

    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Samples what the design sees at each rising edge; the cycle ceiling cuts a hang.
    task automatic tick();
        @(posedge clk);
        prev = cur;
        cur = {fb_clk, ref_clk, outs};
        cyc++;
        if (cyc > 60000) begin
            chk("timeout", 16'h1, 16'h0);
            wrap_up();
        end
    endtask

    task automatic await_lock(input logic v, input int n);
        for (int i = 0; i < n && locked !== v; i++) tick();
        chk("locked", {15'h0, locked}, {15'h0, v});
    endtask

    // Inverted outputs sit half a reference period away.
    function automatic int eff(input int s, input int i, input int p);
        return off[s][i] + ((s < 2 && i == 5) ? p / 2 : 0);
    endfunction

    // Over one reference period, each output must rise at its pattern offset.
    task automatic measure(input int c);
        int p;
        int rel;
        int pos [6];
        int hi [6];
        p = period;
        pos = '{default: -1};
        hi = '{default: 0};
        tick();
        while (!(cur[6] && !prev[6])) tick();
        chk("fb_rise", {14'h0, prev[7], cur[7]}, 16'h1);
        for (int k = 0; k < p; k++) begin
            for (int i = 0; i < 6; i++) begin
                if (cur[i] && !prev[i]) pos[i] = k;
                hi[i] += cur[i];
            end
            for (int i = 1; i < 6; i++) begin
                if (eff(sel, i, p) == eff(sel, 0, p)) begin
                    chk("tied_equal", 16'(cur[i]), 16'(cur[0]));
                end
            end
            if (k < p - 1) tick();
        end
        for (int i = 0; i < 6; i++) begin
            rel = eff(sel, i, p) - eff(sel, fbt[c], p) - dly;
            rel = ((rel % p) + p) % p;
            chk("rise_pos", 16'(pos[i]), 16'(rel));
            chk("high_cnt", 16'(hi[i]), 16'(p / 2));
        end
    endtask

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'hf9c5));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        tick();
        chk("outs_reset", {9'h0, locked, outs}, 16'h0);
        for (int c = 0; c < 14; c++) begin
            // A select change is made while locked; the board wiring only while gated.
            if (sel != 2'((c + 2) / 4)) begin
                @(negedge clk);
                sel = 2'((c + 2) / 4);
                tick();
                tick();
                chk("sel_relock", {15'h0, locked}, 16'h0);
            end
            @(negedge clk);
            gate = 1'b1;
            await_lock(1'b0, 3 * period + 8);
            @(negedge clk);
            period = 4'(8 + c % 5);
            hi_w = 4'(1 + $urandom % (period - 1));
            fb_sel = 3'(fbt[c]);
            dly = 2'(c % 3);
            @(negedge clk);
            gate = 1'b0;
            await_lock(1'b1, 4 * LK);
            measure(c);
        end
        @(negedge clk);
        gate = 1'b1;
        await_lock(1'b0, 3 * period + 8);
        @(negedge clk);
        gate = 1'b0;
        await_lock(1'b1, 4 * LK);
        measure(13);
        wrap_up();
    end
endmodule // testbench
